// File: hdl/lct_pkg.sv
// Purpose: constants for the panel timing generator
// Assumes: 32-bit apb, 20 MHz ref_clk, word-aligned register offsets
// Notes: all counts are in pixel clocks or lines, except the pixel divider, which counts ref clocks
package lct_pkg;
    localparam int unsigned CNT_W = 10;
    localparam int unsigned CMP_W = 12;
    localparam int unsigned COL_W = 6;
    localparam int unsigned DIV_W = 8;
    localparam int unsigned DUTY_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam logic [CNT_W-1:0] MAX_ACTIVE = 10'h200;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PCLK_DIV = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LSYNC_START = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LSYNC_STOP = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_FSYNC_START = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_FSYNC_STOP = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_LINE_TOTAL = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_FRAME_TOTAL = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_ACT_START_CLK = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ACT_START_LIN = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ACT_WIDTH = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_ACT_HEIGHT = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_BACKLIGHT = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h34;

    // control register fields
    localparam int unsigned CTRL_RUN = 0;
    localparam int unsigned CTRL_EDGE = 1;
    localparam int unsigned CTRL_SPREAD = 2;
    localparam int unsigned CTRL_POWER = 3;
    localparam int unsigned CTRL_REVERSE = 4;
    localparam int unsigned CTRL_SWAP_RB = 5;
    localparam int unsigned CTRL_W = 6;
    localparam int unsigned STAT_V_LSB = 16;

    // reset values
    localparam logic [CTRL_W-1:0] RST_CTRL = 6'h00;
    localparam logic [DIV_W-1:0] RST_PCLK_DIV = 8'h03;
    localparam logic [CNT_W-1:0] RST_LSYNC_START = 10'h000;
    localparam logic [CNT_W-1:0] RST_LSYNC_STOP = 10'h00a;
    localparam logic [CNT_W-1:0] RST_FSYNC_START = 10'h000;
    localparam logic [CNT_W-1:0] RST_FSYNC_STOP = 10'h002;
    localparam logic [CNT_W-1:0] RST_LINE_TOTAL = 10'h198;
    localparam logic [CNT_W-1:0] RST_FRAME_TOTAL = 10'h107;
    localparam logic [CNT_W-1:0] RST_ACT_START_CLK = 10'h044;
    localparam logic [CNT_W-1:0] RST_ACT_START_LIN = 10'h012;
    localparam logic [CNT_W-1:0] RST_ACT_WIDTH = 10'h140;
    localparam logic [CNT_W-1:0] RST_ACT_HEIGHT = 10'h0f0;
    localparam logic [DUTY_W-1:0] RST_BACKLIGHT = 8'h80;
endpackage

// File: hdl/lct_pwm.sv
// Purpose: free-running pwm for the backlight driver
// Assumes: duty is a level from the register file on the same clock
// Notes: duty of all ones gives a steady high output
`timescale 1ns/10ps
`default_nettype none
module lct_pwm #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] duty,
    output var logic pwm_q
);
    logic [WIDTH-1:0] count_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end

    // full-scale duty kept high so brightness reaches its top
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= (duty == '1) || (count_q < duty);
        end
    end
endmodule
`default_nettype wire

// File: hdl/lct_timing_top.sv
// Purpose: panel timing generator with apb registers, pixel clock, syncs and rgb out
// Assumes: pixel colour arrives from same-clock logic less than one pixel period after its coordinate
// Notes: no frame buffer; colour is requested per pixel and staged into the output flops
`timescale 1ns/10ps
`default_nettype none
// Contract
// - active area registers accept up to 512 pixels wide and 512 lines tall.
// - origin is upper left; x grows rightward, y downward, scanned in that order.
// - colour leaves as three parallel 6-bit fields, one value per pixel clock.
// - colour bits can be reordered across output pins by configuration.
// - pixel clock frequency is set by a programmable divider.
// - outputs launch on rising or falling pixel clock edge per edge select.
// - frame sync marks frame start, line sync marks line start.
// - line sync starts and stops at programmable pixel clock positions.
// - frame sync starts and stops at programmable line positions.
// - line total clocks and frame total lines are programmable.
// - lines and frames carry blanking around the active region.
// - active region begins programmable clocks and lines after sync start.
// - data enable is high exactly while active colour is driven with spreading off; spread green and blue lag it by one and two ref clocks.
// - data enable derives from the same sync and total settings.
// - with spreading on, colour fields change on staggered ref clock edges.
// - spreading works with either pixel clock edge selection.
// - panel power enable is a host-set general purpose output.
// - a pwm output sets backlight brightness.
module lct_timing_top
    import lct_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire logic [COL_W-1:0] pixel_red,
    input wire logic [COL_W-1:0] pixel_green,
    input wire logic [COL_W-1:0] pixel_blue,
    output var logic [CNT_W-1:0] pixel_x,
    output var logic [CNT_W-1:0] pixel_y,
    output var logic pixel_valid,
    output var logic lcd_pclk,
    output var logic lcd_line_sync_n,
    output var logic lcd_frame_sync_n,
    output var logic lcd_de,
    output var logic [COL_W-1:0] lcd_red,
    output var logic [COL_W-1:0] lcd_green,
    output var logic [COL_W-1:0] lcd_blue,
    output var logic panel_power_enable,
    output var logic backlight_pwm
);
    logic [CTRL_W-1:0] ctrl_q;
    logic [DIV_W-1:0] pclk_div_q;

    logic [CNT_W-1:0] line_sync_start_q, line_sync_stop_q;
    logic [CNT_W-1:0] frame_sync_start_q, frame_sync_stop_q;

    logic [CNT_W-1:0] line_total_clocks_q, frame_total_lines_q;

    logic [CNT_W-1:0] active_start_clocks_q, active_start_lines_q;
    logic [CNT_W-1:0] act_width_q, act_height_q;

    logic [DUTY_W-1:0] backlight_q;

    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic setup, wr_en, addr_ok;
    logic [31:0] rd_word;

    logic [DIV_W-1:0] div_cnt_q;
    logic pclk_q, tick, tick_d1_q, tick_d2_q, run;

    logic [CNT_W-1:0] h_q, v_q, h_nx, v_nx;
    logic h_last, v_last;

    logic [CMP_W-1:0] h_act_lo, h_act_hi, v_act_lo, v_act_hi;
    logic in_act_nx;

    logic [CNT_W-1:0] x_q, y_q;
    logic valid_q, de_q, lsync_n_q, fsync_n_q;

    logic [COL_W-1:0] sw_r, sw_g, sw_b;
    logic [COL_W-1:0] red_q, green_q, blue_q, hold_g_q, hold_b_q;

    logic [CNT_W-1:0] wr_cnt;

    function automatic logic [COL_W-1:0] rev6(input logic [COL_W-1:0] c);
        return {<<{c}};
    endfunction

    // apb: setup cycle loads the answer, pready rises in the first access cycle
    assign setup = psel && !penable && !pready_q;
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

    assign wr_cnt = pwdata[CNT_W-1:0];

    always_comb begin
        addr_ok = 1'b1;
        rd_word = '0;
        unique case (paddr)
            OFS_CTRL: rd_word[CTRL_W-1:0] = ctrl_q;
            OFS_PCLK_DIV: rd_word[DIV_W-1:0] = pclk_div_q;
            OFS_LSYNC_START: rd_word[CNT_W-1:0] = line_sync_start_q;
            OFS_LSYNC_STOP: rd_word[CNT_W-1:0] = line_sync_stop_q;
            OFS_FSYNC_START: rd_word[CNT_W-1:0] = frame_sync_start_q;
            OFS_FSYNC_STOP: rd_word[CNT_W-1:0] = frame_sync_stop_q;
            OFS_LINE_TOTAL: rd_word[CNT_W-1:0] = line_total_clocks_q;
            OFS_FRAME_TOTAL: rd_word[CNT_W-1:0] = frame_total_lines_q;
            OFS_ACT_START_CLK: rd_word[CNT_W-1:0] = active_start_clocks_q;
            OFS_ACT_START_LIN: rd_word[CNT_W-1:0] = active_start_lines_q;
            OFS_ACT_WIDTH: rd_word[CNT_W-1:0] = act_width_q;
            OFS_ACT_HEIGHT: rd_word[CNT_W-1:0] = act_height_q;
            OFS_BACKLIGHT: rd_word[DUTY_W-1:0] = backlight_q;
            OFS_STATUS: begin
                rd_word[CNT_W-1:0] = h_q;
                rd_word[STAT_V_LSB +: CNT_W] = v_q;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= !addr_ok;
                prdata_q <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_word;
            end else if (pready_q) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= RST_CTRL;
            pclk_div_q <= RST_PCLK_DIV;
            line_sync_start_q <= RST_LSYNC_START;
            line_sync_stop_q <= RST_LSYNC_STOP;
            frame_sync_start_q <= RST_FSYNC_START;
            frame_sync_stop_q <= RST_FSYNC_STOP;
            line_total_clocks_q <= RST_LINE_TOTAL;
            frame_total_lines_q <= RST_FRAME_TOTAL;
            active_start_clocks_q <= RST_ACT_START_CLK;
            active_start_lines_q <= RST_ACT_START_LIN;
            act_width_q <= RST_ACT_WIDTH;
            act_height_q <= RST_ACT_HEIGHT;
            backlight_q <= RST_BACKLIGHT;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: ctrl_q <= pwdata[CTRL_W-1:0];
                OFS_PCLK_DIV: pclk_div_q <= pwdata[DIV_W-1:0];
                OFS_LSYNC_START: line_sync_start_q <= wr_cnt;
                OFS_LSYNC_STOP: line_sync_stop_q <= wr_cnt;
                OFS_FSYNC_START: frame_sync_start_q <= wr_cnt;
                OFS_FSYNC_STOP: frame_sync_stop_q <= wr_cnt;
                OFS_LINE_TOTAL: line_total_clocks_q <= wr_cnt;
                OFS_FRAME_TOTAL: frame_total_lines_q <= wr_cnt;
                OFS_ACT_START_CLK: active_start_clocks_q <= wr_cnt;
                OFS_ACT_START_LIN: active_start_lines_q <= wr_cnt;
                // larger sizes are clipped to the supported maximum
                OFS_ACT_WIDTH: act_width_q <= (wr_cnt > MAX_ACTIVE) ? MAX_ACTIVE : wr_cnt;
                OFS_ACT_HEIGHT: act_height_q <= (wr_cnt > MAX_ACTIVE) ? MAX_ACTIVE : wr_cnt;
                OFS_BACKLIGHT: backlight_q <= pwdata[DUTY_W-1:0];
                default: ;
            endcase
        end
    end

    assign run = ctrl_q[CTRL_RUN];

    // pixel clock: half period is div+1 ref clocks
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= '0;
            pclk_q <= 1'b0;
        end else if (!run) begin
            div_cnt_q <= '0;
            pclk_q <= 1'b0;
        end else if (div_cnt_q >= pclk_div_q) begin
            div_cnt_q <= '0;
            pclk_q <= !pclk_q;
        end else begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    // launch edge: rising when edge select is 0, falling when 1; panel samples
    // half a pixel period later, so setup and hold are both half a period
    assign tick = run && (div_cnt_q >= pclk_div_q) && (pclk_q == ctrl_q[CTRL_EDGE]);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_d1_q <= 1'b0;
            tick_d2_q <= 1'b0;
        end else begin
            tick_d1_q <= tick;
            tick_d2_q <= tick_d1_q;
        end
    end

    // scan counters
    assign h_last = (h_q >= line_total_clocks_q - 1'b1);
    assign v_last = (v_q >= frame_total_lines_q - 1'b1);

    assign h_nx = h_last ? '0 : h_q + 1'b1;
    assign v_nx = !h_last ? v_q : (v_last ? '0 : v_q + 1'b1);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            h_q <= '0;
            v_q <= '0;
        end else if (!run) begin
            h_q <= '0;
            v_q <= '0;
        end else if (tick) begin
            h_q <= h_nx;
            v_q <= v_nx;
        end
    end

    // active window measured from sync start, widened to avoid wrap
    assign h_act_lo = CMP_W'(line_sync_start_q) + CMP_W'(active_start_clocks_q);
    assign h_act_hi = h_act_lo + CMP_W'(act_width_q);
    assign v_act_lo = CMP_W'(frame_sync_start_q) + CMP_W'(active_start_lines_q);
    assign v_act_hi = v_act_lo + CMP_W'(act_height_q);

    assign in_act_nx = (CMP_W'(h_nx) >= h_act_lo) && (CMP_W'(h_nx) < h_act_hi)
                    && (CMP_W'(v_nx) >= v_act_lo) && (CMP_W'(v_nx) < v_act_hi);

    // coordinate request runs one pixel ahead of the panel outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            x_q <= '0;
            y_q <= '0;
            valid_q <= 1'b0;
        end else if (!run) begin
            x_q <= '0;
            y_q <= '0;
            valid_q <= 1'b0;
        end else if (tick) begin
            x_q <= CNT_W'(CMP_W'(h_nx) - h_act_lo);
            y_q <= CNT_W'(CMP_W'(v_nx) - v_act_lo);
            valid_q <= in_act_nx;
        end
    end

    // syncs and data enable all follow the counters held in h_q and v_q
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lsync_n_q <= 1'b1;
            fsync_n_q <= 1'b1;
            de_q <= 1'b0;
        end else if (!run) begin
            lsync_n_q <= 1'b1;
            fsync_n_q <= 1'b1;
            de_q <= 1'b0;
        end else if (tick) begin
            lsync_n_q <= !((h_q >= line_sync_start_q) && (h_q < line_sync_stop_q));
            fsync_n_q <= !((v_q >= frame_sync_start_q) && (v_q < frame_sync_stop_q));
            de_q <= valid_q;
        end
    end

    // pin reordering: optional red/blue swap, then bit reversal per field
    always_comb begin
        sw_r = ctrl_q[CTRL_SWAP_RB] ? pixel_blue : pixel_red;
        sw_g = pixel_green;
        sw_b = ctrl_q[CTRL_SWAP_RB] ? pixel_red : pixel_blue;
        if (ctrl_q[CTRL_REVERSE]) begin
            sw_r = rev6(sw_r);
            sw_g = rev6(sw_g);
            sw_b = rev6(sw_b);
        end
    end

    // spreading delays green by one and blue by two ref clocks; needs a half
    // period of at least three ref clocks to settle before the sample edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            red_q <= '0;
            green_q <= '0;
            blue_q <= '0;
            hold_g_q <= '0;
            hold_b_q <= '0;
        end else if (!run) begin
            red_q <= '0;
            green_q <= '0;
            blue_q <= '0;
            hold_g_q <= '0;
            hold_b_q <= '0;
        end else begin
            if (tick) begin
                red_q <= valid_q ? sw_r : '0;
                hold_g_q <= valid_q ? sw_g : '0;
                hold_b_q <= valid_q ? sw_b : '0;
            end
            if (ctrl_q[CTRL_SPREAD]) begin
                if (tick_d1_q) begin
                    green_q <= hold_g_q;
                end
                if (tick_d2_q) begin
                    blue_q <= hold_b_q;
                end
            end else if (tick) begin
                green_q <= valid_q ? sw_g : '0;
                blue_q <= valid_q ? sw_b : '0;
            end
        end
    end

    lct_pwm #(
        .WIDTH(DUTY_W)
    ) u_backlight (
        .clk(ref_clk),
        .arst_n(arst_n),
        .duty(backlight_q),
        .pwm_q(backlight_pwm)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    assign pixel_x = x_q;
    assign pixel_y = y_q;
    assign pixel_valid = valid_q;

    assign lcd_pclk = pclk_q;
    assign lcd_line_sync_n = lsync_n_q;
    assign lcd_frame_sync_n = fsync_n_q;
    assign lcd_de = de_q;
    assign lcd_red = red_q;
    assign lcd_green = green_q;
    assign lcd_blue = blue_q;

    assign panel_power_enable = ctrl_q[CTRL_POWER];
endmodule
`default_nettype wire

// File: tb/lct_timing_top_props.sv
// Purpose: port checks for the panel timing generator
// Assumes: pixel divider kept at 2 or more
// Notes: attached by the bind below
`timescale 1ns/10ps
`default_nettype none
module lct_timing_props
    import lct_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [CNT_W-1:0] pixel_x,
    input wire logic [CNT_W-1:0] pixel_y,
    input wire logic pixel_valid,
    input wire logic lcd_pclk,
    input wire logic lcd_line_sync_n,
    input wire logic lcd_frame_sync_n,
    input wire logic lcd_de,
    input wire logic [COL_W-1:0] lcd_red,
    input wire logic [COL_W-1:0] lcd_green,
    input wire logic [COL_W-1:0] lcd_blue,
    input wire logic panel_power_enable
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready missing");
    property p_err;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("error response bad");
    // spread delays blue two clocks, so look back that far
    property p_quiet;
        !lcd_de && !$past(lcd_de) && !$past(lcd_de, 2) |-> {lcd_red, lcd_green, lcd_blue} == 18'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("colour outside enable");
    property p_de_pclk;
        $changed(lcd_de) |-> $changed(lcd_pclk);
    endproperty
    a_de_pclk: assert property (p_de_pclk) else $error("enable off pixel edge");
    property p_sync_pclk;
        $changed(lcd_line_sync_n) || $changed(lcd_frame_sync_n) |-> $changed(lcd_pclk);
    endproperty
    a_sync_pclk: assert property (p_sync_pclk) else $error("sync off pixel edge");
    property p_x_step;
        pixel_valid && $past(pixel_valid) && pixel_y == $past(pixel_y)
            && pixel_x != $past(pixel_x) |-> pixel_x == $past(pixel_x) + 10'h001;
    endproperty
    a_x_step: assert property (p_x_step) else $error("x not stepping");
    property p_power;
        $changed(panel_power_enable) |-> $past(psel && penable && pready && pwrite);
    endproperty
    a_power: assert property (p_power) else $error("power moved alone");
    property p_half;
        $changed(lcd_pclk) |=> $stable(lcd_pclk) [*2];
    endproperty
    a_half: assert property (p_half) else $error("pixel clock too fast");
    c_de: cover property ($rose(lcd_de));
    c_err: cover property (pslverr);
    c_power: cover property ($rose(panel_power_enable));
endmodule
bind lct_timing_top lct_timing_props u_props (
    .ref_clk, .arst_n, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .pixel_x,
    .pixel_y, .pixel_valid, .lcd_pclk, .lcd_line_sync_n, .lcd_frame_sync_n, .lcd_de,
    .lcd_red, .lcd_green, .lcd_blue, .panel_power_enable
);
`default_nettype wire

// File: tb/lct_panel_model.sv
// Purpose: panel receiver that latches pixels and counts them
// Assumes: pixel clock sampled by ref_clk
// Notes: counts enabled pixels per line and lines holding them per frame
`timescale 1ns/10ps
`default_nettype none
module lct_panel_model
    import lct_pkg::*;
(
    input wire logic ref_clk,
    input wire logic edge_sel,
    input wire logic lcd_pclk,
    input wire logic lcd_line_sync_n,
    input wire logic lcd_frame_sync_n,
    input wire logic lcd_de,
    input wire logic [COL_W-1:0] lcd_red,
    input wire logic [COL_W-1:0] lcd_green,
    input wire logic [COL_W-1:0] lcd_blue,
    output var logic [CNT_W-1:0] line_px = 10'h000,
    output var logic [CNT_W-1:0] frame_lines = 10'h000,
    output var logic [3*COL_W-1:0] last_col = 18'h0
);
    logic pclk_q = 1'b0, hs_q = 1'b1, vs_q = 1'b1;
    logic [CNT_W-1:0] cnt = 10'h000, lines = 10'h000;
    always @(posedge ref_clk) begin
        pclk_q <= lcd_pclk;
        // latch on the edge opposite the launch, as a panel would
        if (lcd_pclk != pclk_q && lcd_pclk == edge_sel) begin
            hs_q <= lcd_line_sync_n;
            vs_q <= lcd_frame_sync_n;
            if (lcd_de) begin
                cnt <= cnt + 10'h001;
                last_col <= {lcd_red, lcd_green, lcd_blue};
            end
            if (hs_q && !lcd_line_sync_n) begin
                cnt <= 10'h000;
                if (cnt != 10'h000) begin
                    line_px <= cnt;
                    lines <= lines + 10'h001;
                end
            end
            if (vs_q && !lcd_frame_sync_n) begin
                frame_lines <= lines;
                lines <= 10'h000;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_lcd_panel_timing_generator.sv
// Purpose: self-checking bench for the panel timing generator
// Assumes: small geometry, pixel divider 2 (six clocks a pixel)
// Notes: run bit stays set once the frame test starts
`timescale 1ns/10ps
`default_nettype none
module tb_lcd_panel_timing_generator
    import lct_pkg::*;
;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, edge_bit = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [COL_W-1:0] pixel_red = 6'h00, pixel_green = 6'h00, pixel_blue = 6'h00;
    logic [COL_W-1:0] lcd_red, lcd_green, lcd_blue;
    logic [CNT_W-1:0] pixel_x, pixel_y, line_px, frame_lines;
    logic [3*COL_W-1:0] last_col;
    logic pready, pslverr, pixel_valid, lcd_pclk, lcd_line_sync_n, lcd_frame_sync_n;
    logic lcd_de, panel_power_enable, backlight_pwm;
    int err_count = 0, checks = 0, cyc = 0;
    lct_timing_top DUT (
        .ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pixel_red, .pixel_green, .pixel_blue, .pixel_x, .pixel_y, .pixel_valid,
        .lcd_pclk, .lcd_line_sync_n, .lcd_frame_sync_n, .lcd_de, .lcd_red, .lcd_green,
        .lcd_blue, .panel_power_enable, .backlight_pwm
    );
    lct_panel_model u_panel (
        .ref_clk, .edge_sel(edge_bit), .lcd_pclk, .lcd_line_sync_n, .lcd_frame_sync_n,
        .lcd_de, .lcd_red, .lcd_green, .lcd_blue, .line_px, .frame_lines, .last_col
    );
    always #25 ref_clk = ~ref_clk;
    // colour tracks the coordinate so every pixel differs
    always @(posedge ref_clk) begin
        pixel_red <= pixel_x[5:0] + 6'h01;
        pixel_green <= pixel_y[5:0] + 6'h21;
        pixel_blue <= pixel_x[5:0] + 6'h10;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        chk($sformatf("reg %h", a), exp, rd);
    endtask
    function automatic logic sel(input int w);
        return w == 0 ? lcd_line_sync_n : (w == 1 ? lcd_frame_sync_n : lcd_de);
    endfunction
    task automatic wait_lvl(input int w, input logic v, output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (sel(w) !== v);
    endtask
    task automatic frames(input int k);
        int n;
        repeat (k) begin
            wait_lvl(1, 1'b1, n);
            wait_lvl(1, 1'b0, n);
        end
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic t_reset();
        logic [31:0] rd;
        logic er;
        chk("idle", 32'h6, {27'h0, panel_power_enable, lcd_pclk, lcd_line_sync_n,
            lcd_frame_sync_n, lcd_de});
        rd_chk(OFS_CTRL, 32'(RST_CTRL));
        rd_chk(OFS_PCLK_DIV, 32'(RST_PCLK_DIV));
        rd_chk(OFS_LINE_TOTAL, 32'(RST_LINE_TOTAL));
        rd_chk(OFS_FRAME_TOTAL, 32'(RST_FRAME_TOTAL));
        rd_chk(OFS_BACKLIGHT, 32'(RST_BACKLIGHT));
        rd_chk(OFS_STATUS, 32'h0);
        wr(OFS_ACT_WIDTH, 32'h3ff);
        rd_chk(OFS_ACT_WIDTH, 32'h200);
        apb(1'b0, 8'h38, 32'h0, rd, er);
        chk("unmapped", 32'h1, {31'h0, er});
    endtask
    task automatic t_frame();
        wr(OFS_PCLK_DIV, 32'h2);
        wr(OFS_LSYNC_START, 32'h1);
        wr(OFS_LSYNC_STOP, 32'h3);
        wr(OFS_FSYNC_START, 32'h1);
        wr(OFS_FSYNC_STOP, 32'h2);
        wr(OFS_LINE_TOTAL, 32'h14);
        wr(OFS_FRAME_TOTAL, 32'hc);
        wr(OFS_ACT_START_CLK, 32'h4);
        wr(OFS_ACT_START_LIN, 32'h2);
        wr(OFS_ACT_WIDTH, 32'h8);
        wr(OFS_ACT_HEIGHT, 32'h5);
        wr(OFS_CTRL, 32'h1);
        frames(2);
        chk("line_px", 32'h8, 32'(line_px));
        chk("frame_lines", 32'h5, 32'(frame_lines));
        chk("last_col", 32'h8957, 32'(last_col));
    endtask
    task automatic t_sync();
        int n, lo, hi;
        wait_lvl(0, 1'b1, n);
        wait_lvl(0, 1'b0, n);
        wait_lvl(0, 1'b1, lo);
        wait_lvl(0, 1'b0, hi);
        chk("lsync_low", 32'h0c, lo);
        chk("line_per", 32'h78, lo + hi);
        wait_lvl(1, 1'b1, n);
        wait_lvl(1, 1'b0, n);
        wait_lvl(1, 1'b1, lo);
        wait_lvl(1, 1'b0, hi);
        chk("fsync_low", 32'h78, lo);
        chk("frame_per", 32'h5a0, lo + hi);
        wait_lvl(2, 1'b1, n);
        chk("v_offset", 32'h10e, n);
        wait_lvl(2, 1'b0, n);
        chk("de_width", 32'h30, n);
        wait_lvl(0, 1'b0, n);
        wait_lvl(2, 1'b1, n);
        chk("h_offset", 32'h18, n);
    endtask
    task automatic t_edge();
        int n;
        for (int k = 0; k < 4; k++) begin
            edge_bit <= k[0];
            wr(OFS_CTRL, {29'h0, k[1], k[0], 1'b1});
            frames(1);
            wait_lvl(2, 1'b1, n);
            chk("pclk_at_de", {31'h0, ~k[0]}, {31'h0, lcd_pclk});
            chk("green_now", {31'h0, ~k[1]}, {31'h0, lcd_green != 6'h00});
            @(posedge ref_clk);
            chk("green_next", 32'h1, {31'h0, lcd_green != 6'h00});
            chk("blue_next", {31'h0, ~k[1]}, {31'h0, lcd_blue != 6'h00});
        end
        frames(1);
        chk("spread_px", 32'h8, 32'(line_px));
        chk("spread_col", 32'h8957, 32'(last_col));
        edge_bit <= 1'b0;
        wr(OFS_CTRL, 32'h1);
    endtask
    task automatic t_order();
        wr(OFS_CTRL, 32'h11);
        frames(2);
        chk("rev_col", 32'h4a7a, 32'(last_col));
        wr(OFS_CTRL, 32'h21);
        frames(2);
        chk("swap_col", 32'h17948, 32'(last_col));
    endtask
    task automatic t_power();
        wr(OFS_CTRL, 32'h9);
        chk("power_on", 32'h1, {31'h0, panel_power_enable});
        wr(OFS_CTRL, 32'h1);
        chk("power_off", 32'h0, {31'h0, panel_power_enable});
    endtask
    task automatic t_pwm();
        int n;
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            d = (i == 0) ? 8'h40 : 8'hff;
            wr(OFS_BACKLIGHT, {24'h0, d});
            repeat (256) @(posedge ref_clk);
            n = 0;
            repeat (256) begin
                @(posedge ref_clk);
                if (backlight_pwm === 1'b1) n++;
            end
            chk("pwm_high", (i == 0) ? 32'h40 : 32'h100, n);
        end
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_frame();
        t_sync();
        t_edge();
        t_order();
        t_power();
        t_pwm();
        close_out();
    end
endmodule
`default_nettype wire
